// [tcc_pkg.sv]
// Package: register map, field layout and constants of the 16-bit capture/compare timer
package tcc_pkg;
	// ==========================================
	// Register offsets (byte addresses)
	localparam logic [7:0] OFS_MODE = 8'h00;
	localparam logic [7:0] OFS_CCCTRL = 8'h04;
	localparam logic [7:0] OFS_PRESC = 8'h08;
	localparam logic [7:0] OFS_COUNT = 8'h0c;
	localparam logic [7:0] OFS_CCFIRST = 8'h10;
	localparam logic [7:0] OFS_CCSECOND = 8'h14;
	localparam logic [7:0] OFS_IRQ_STAT = 8'h18;
	localparam logic [7:0] OFS_IRQ_MASK = 8'h1c;
	localparam logic [7:0] OFS_PINCFG = 8'h20;
	// ==========================================
	// Field positions
	localparam int OPM_LO = 2;
	localparam int OPM_HI = 3;
	localparam int CC0_CMP = 0;
	localparam int CC0_REV = 1;
	localparam int CC1_CMP = 2;
	localparam int EDG0_LO = 0;
	localparam int EDG1_LO = 2;
	localparam int EDG_W = 2;
	// ==========================================
	// Values after reset, and the edge-input clock select
	localparam logic [1:0] OPM_STOP = 2'h0;
	localparam logic [1:0] CLKSEL_EDGE = 2'h3;
	localparam logic [3:0] MODE_RST = 4'h0;
	localparam logic [2:0] CCCTRL_RST = 3'h0;
	localparam logic [7:0] PRESC_RST = 8'h00;
	localparam logic [2:0] IRQ_MASK_RST = 3'h7;
	localparam logic [15:0] CNT_RST = 16'h0000;
	// ==========================================
	// Edge select encodings
	localparam logic [1:0] EDG_FALL = 2'h0;
	localparam logic [1:0] EDG_RISE = 2'h1;
	localparam logic [1:0] EDG_NONE = 2'h2;
	localparam logic [1:0] EDG_BOTH = 2'h3;
	// Prescaler divide exponents for select 00..10
	localparam logic [3:0] DIV_EXP0 = 4'h0;
	localparam logic [3:0] DIV_EXP1 = 4'h2;
	localparam logic [3:0] DIV_EXP2 = 4'h8;
	// Interrupt status bits
	localparam int IRQ_CC0 = 0;
	localparam int IRQ_CC1 = 1;
	localparam int IRQ_OVF = 2;

	typedef struct packed {
		logic [1:0] opm;
		logic cc0_cmp;
		logic cc0_rev;
		logic cc1_cmp;
		logic [1:0] clksel;
		logic [1:0] edge0;
		logic [1:0] edge1;
		logic pin_is_out;
	} tcc_cfg_s;

	typedef enum logic [2:0] {
		ST_STOP = 3'b001,
		ST_FIRST = 3'b010,
		ST_RUN = 3'b100
	} tcc_run_e;
endpackage

// [tcc_presc.sv]
// Prescaler: produces the one-cycle count-clock enable
`timescale 1ns/1ps
module tcc_presc
	import tcc_pkg::*;
#(
	parameter int W = 16
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Control
	input wire logic run,
	input wire logic [1:0] sel,
	input wire logic ext_tick,
	// Enable out
	output logic tick
);
	logic [W-1:0] div_r;
	logic [3:0] exp_w;

	always_comb begin
		case (sel)
			2'h0: exp_w = DIV_EXP0;
			2'h1: exp_w = DIV_EXP1;
			default: exp_w = DIV_EXP2;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_r <= '0;
		end else if (!run) begin
			div_r <= '0;
		end else begin
			div_r <= div_r + 1'b1;
		end
	end

	// Counter enable from divider, or edge input when select is 11
	always_comb begin
		if (!run) begin
			tick = 1'b0;
		end else if (sel == CLKSEL_EDGE) begin
			tick = ext_tick;
		end else if (exp_w == 4'h0) begin
			tick = 1'b1;
		end else begin
			tick = ((div_r & ((W'(1) << exp_w) - W'(1))) == '0);
		end
	end
endmodule

// [tcc_edge.sv]
// Edge detector for one external edge input with first-enable rising detection
`timescale 1ns/1ps
module tcc_edge
	import tcc_pkg::*;
(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Control
	input wire logic run,
	input wire logic first_en,
	input wire logic [1:0] sel,
	// Pin
	input wire logic pin,
	// Events
	output logic valid,
	output logic opposite
);
	logic prev_r;
	logic rise_w;
	logic fall_w;

	// On the very first enable the previous level is seen as low
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prev_r <= 1'b0;
		end else if (run || first_en) begin
			prev_r <= pin;
		end
	end

	assign rise_w = run && pin && !prev_r;
	assign fall_w = run && !pin && prev_r;

	always_comb begin
		case (sel)
			EDG_FALL: begin
				valid = fall_w;
				opposite = rise_w;
			end
			EDG_RISE: begin
				valid = rise_w;
				opposite = fall_w;
			end
			EDG_BOTH: begin
				valid = rise_w || fall_w;
				opposite = 1'b0;
			end
			default: begin
				valid = 1'b0;
				opposite = 1'b0;
			end
		endcase
	end
endmodule

// [tcc_top.sv]
// Top: 16-bit timer with two capture/compare registers and an APB slave
//
// Decided for this implementation: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
// Function
// - Shared pin carries second edge input or timer output, selected by config.
// - Stopping in the same cycle as a capture leaves the capture undefined.
// - First register keeps a captured value until device reset.
// - Reading the count has no side effect; no load of second register.
// - First register in compare mode ignores all capture triggers.
// - Second register in compare mode ignores all capture triggers.
// - Opposite-phase capture into first register raises no interrupt.
// - Then a second-input edge does not capture; raises first-register interrupt.
// - Non-zero operating mode starts the counter; 00 stops it.
// - First enable with input high and rising edge detects a rising edge.
module tcc_top
	import tcc_pkg::*;
#(
	parameter int CNT_W = 16
) (
	// APB
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Edge inputs
	input wire logic edge_input_first,
	input wire logic shared_port_pin_in,
	// Shared pin drive
	output logic shared_port_pin_out,
	output logic shared_port_pin_oe,
	// Interrupt
	output logic irq
);
	// ==========================================
	// Registers
	logic [3:0] timer_mode_control_reg;
	logic [2:0] capture_compare_ctrl_reg;
	logic [7:0] prescaler_mode_reg;
	logic [4:0] pincfg_r;
	logic [CNT_W-1:0] timer_count_value;
	logic [CNT_W-1:0] capture_compare_first;
	logic [CNT_W-1:0] capture_compare_second;
	logic [2:0] irq_stat_r;
	logic [2:0] irq_mask_r;
	logic toggle_r;
	tcc_run_e run_r;
	tcc_cfg_s cfg;

	logic wr_w;
	logic rd_w;
	logic run_w;
	logic tick_w;
	logic v0_w;
	logic o0_w;
	logic v1_w;
	logic o1_w;
	logic edge_input_second;
	logic cap0_w;
	logic cap1_w;
	logic ext_irq_w;
	logic m0_w;
	logic m1_w;
	logic ovf_w;
	logic [2:0] ev_w;

	function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
		hit = (a == o);
	endfunction

	assign cfg.opm = timer_mode_control_reg[OPM_HI:OPM_LO];
	assign cfg.cc0_cmp = capture_compare_ctrl_reg[CC0_CMP];
	assign cfg.cc0_rev = capture_compare_ctrl_reg[CC0_REV];
	assign cfg.cc1_cmp = capture_compare_ctrl_reg[CC1_CMP];
	assign cfg.clksel = prescaler_mode_reg[1:0];
	assign cfg.edge0 = prescaler_mode_reg[4+EDG0_LO +: EDG_W];
	assign cfg.edge1 = prescaler_mode_reg[4+EDG1_LO +: EDG_W];
	assign cfg.pin_is_out = pincfg_r[0];

	assign wr_w = psel && penable && pwrite;
	assign rd_w = psel && penable && !pwrite;

	// ==========================================
	// Run control
	assign run_w = (cfg.opm != OPM_STOP);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			run_r <= ST_STOP;
		end else begin
			case (run_r)
				ST_STOP: run_r <= run_w ? ST_FIRST : ST_STOP;
				ST_FIRST: run_r <= run_w ? ST_RUN : ST_STOP;
				ST_RUN: run_r <= run_w ? ST_RUN : ST_STOP;
				default: run_r <= ST_STOP;
			endcase
		end
	end

	// First enable ever: edge prev level held low until then
	logic ever_r;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ever_r <= 1'b0;
		end else if (run_w) begin
			ever_r <= 1'b1;
		end
	end

	// ==========================================
	// Pin mux and edges
	assign edge_input_second = cfg.pin_is_out ? 1'b0 : shared_port_pin_in;

	tcc_edge u_edge0 (
		.pclk(pclk),
		.presetn(presetn),
		.run(run_w),
		.first_en(ever_r),
		.sel(cfg.edge0),
		.pin(edge_input_first),
		.valid(v0_w),
		.opposite(o0_w)
	);

	tcc_edge u_edge1 (
		.pclk(pclk),
		.presetn(presetn),
		.run(run_w),
		.first_en(ever_r),
		.sel(cfg.edge1),
		.pin(edge_input_second),
		.valid(v1_w),
		.opposite(o1_w)
	);

	tcc_presc #(.W(CNT_W)) u_presc (
		.pclk(pclk),
		.presetn(presetn),
		.run(run_w),
		.sel(cfg.clksel),
		.ext_tick(v0_w),
		.tick(tick_w)
	);

	// ==========================================
	// Counter
	assign ovf_w = tick_w && (timer_count_value == {CNT_W{1'b1}});

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			timer_count_value <= CNT_RST;
		end else if (!run_w) begin
			timer_count_value <= CNT_RST;
		end else if (tick_w) begin
			timer_count_value <= timer_count_value + 1'b1;
		end
	end

	// ==========================================
	// Capture triggers
	// Reverse phase: first register captures on opposite edge of first input
	assign cap0_w = run_w && !cfg.cc0_cmp && (cfg.cc0_rev ? o0_w : v1_w)
		&& (cfg.clksel != CLKSEL_EDGE);
	assign cap1_w = run_w && !cfg.cc1_cmp && v0_w && (cfg.clksel != CLKSEL_EDGE);
	assign ext_irq_w = run_w && !cfg.cc0_cmp && cfg.cc0_rev && v1_w;
	assign m0_w = run_w && cfg.cc0_cmp && tick_w && (timer_count_value == capture_compare_first);
	assign m1_w = run_w && cfg.cc1_cmp && tick_w && (timer_count_value == capture_compare_second);

	// First register: capture, or software write while in compare mode
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			capture_compare_first <= CNT_RST;
		end else if (cap0_w) begin
			capture_compare_first <= timer_count_value;
		end else if (wr_w && hit(paddr, OFS_CCFIRST) && cfg.cc0_cmp) begin
			capture_compare_first <= pwdata[CNT_W-1:0];
		end
	end

	// Second register: reading the count never loads it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			capture_compare_second <= CNT_RST;
		end else if (cap1_w) begin
			capture_compare_second <= timer_count_value;
		end else if (wr_w && hit(paddr, OFS_CCSECOND) && cfg.cc1_cmp) begin
			capture_compare_second <= pwdata[CNT_W-1:0];
		end
	end

	// ==========================================
	// Interrupt status (set wins over read-clear)
	assign ev_w[IRQ_CC0] = (cap0_w && !cfg.cc0_rev) || ext_irq_w || m0_w;
	assign ev_w[IRQ_CC1] = cap1_w || m1_w;
	assign ev_w[IRQ_OVF] = ovf_w;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_stat_r <= '0;
		end else if (rd_w && hit(paddr, OFS_IRQ_STAT)) begin
			irq_stat_r <= ev_w;
		end else begin
			irq_stat_r <= irq_stat_r | ev_w;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq <= 1'b0;
		end else begin
			irq <= |((irq_stat_r | ev_w) & ~irq_mask_r & ~((rd_w && hit(paddr, OFS_IRQ_STAT))
				? irq_stat_r : 3'h0));
		end
	end

	// ==========================================
	// Timer output on shared pin, toggles on second-register match
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			toggle_r <= 1'b0;
		end else if (!run_w) begin
			toggle_r <= 1'b0;
		end else if (m1_w) begin
			toggle_r <= ~toggle_r;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			shared_port_pin_out <= 1'b0;
			shared_port_pin_oe <= 1'b0;
		end else begin
			shared_port_pin_out <= cfg.pin_is_out & toggle_r;
			shared_port_pin_oe <= cfg.pin_is_out;
		end
	end

	// ==========================================
	// Register writes
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			timer_mode_control_reg <= MODE_RST;
			capture_compare_ctrl_reg <= CCCTRL_RST;
			prescaler_mode_reg <= PRESC_RST;
			irq_mask_r <= IRQ_MASK_RST;
			pincfg_r <= '0;
		end else if (wr_w) begin
			if (hit(paddr, OFS_MODE)) begin
				timer_mode_control_reg <= pwdata[3:0];
			end
			if (hit(paddr, OFS_CCCTRL)) begin
				capture_compare_ctrl_reg <= pwdata[2:0];
			end
			if (hit(paddr, OFS_PRESC)) begin
				prescaler_mode_reg <= pwdata[7:0];
			end
			if (hit(paddr, OFS_IRQ_MASK)) begin
				irq_mask_r <= pwdata[2:0];
			end
			if (hit(paddr, OFS_PINCFG)) begin
				pincfg_r <= pwdata[4:0];
			end
		end
	end

	// ==========================================
	// APB read and answer: no wait states
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= '0;
		end else if (psel && !penable) begin
			pready <= 1'b1;
			pslverr <= !(hit(paddr, OFS_MODE) || hit(paddr, OFS_CCCTRL) || hit(paddr, OFS_PRESC)
				|| hit(paddr, OFS_COUNT) || hit(paddr, OFS_CCFIRST) || hit(paddr, OFS_CCSECOND)
				|| hit(paddr, OFS_IRQ_STAT) || hit(paddr, OFS_IRQ_MASK) || hit(paddr, OFS_PINCFG));
			case (paddr)
				OFS_MODE: prdata <= {28'h0, timer_mode_control_reg};
				OFS_CCCTRL: prdata <= {29'h0, capture_compare_ctrl_reg};
				OFS_PRESC: prdata <= {24'h0, prescaler_mode_reg};
				OFS_COUNT: prdata <= {{(32-CNT_W){1'b0}}, timer_count_value};
				OFS_CCFIRST: prdata <= {{(32-CNT_W){1'b0}}, capture_compare_first};
				OFS_CCSECOND: prdata <= {{(32-CNT_W){1'b0}}, capture_compare_second};
				OFS_IRQ_STAT: prdata <= {29'h0, irq_stat_r | ev_w};
				OFS_IRQ_MASK: prdata <= {29'h0, irq_mask_r};
				OFS_PINCFG: prdata <= {27'h0, pincfg_r};
				default: prdata <= 32'h0;
			endcase
		end else begin
			pready <= 1'b0;
			pslverr <= 1'b0;
		end
	end
endmodule

// [tcc_monitor.sv]
// Checker: bus handshake and register relations seen at the timer ports
`timescale 1ns/1ps
module tcc_monitor
	import tcc_pkg::*;
#(
	parameter int CNT_W = 16
) (
	// APB
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// Pins
	input wire logic edge_input_first,
	input wire logic shared_port_pin_in,
	input wire logic shared_port_pin_out,
	input wire logic shared_port_pin_oe,
	input wire logic irq
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// ==========================================
	// Register shadows
	logic acc;
	logic wr;
	logic [2:0] mask_r;
	logic pin_r;
	logic [1:0] opm_r;
	logic [1:0] stop_cnt_r;
	assign acc = psel && penable && pready;
	assign wr = acc && pwrite;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mask_r <= IRQ_MASK_RST;
			pin_r <= 1'b0;
		end else if (wr && paddr == OFS_IRQ_MASK) begin
			mask_r <= pwdata[2:0];
		end else if (wr && paddr == OFS_PINCFG) begin
			pin_r <= pwdata[0];
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			opm_r <= OPM_STOP;
			stop_cnt_r <= 2'h3;
		end else if (wr && paddr == OFS_MODE) begin
			opm_r <= pwdata[OPM_HI:OPM_LO];
			stop_cnt_r <= 2'h0;
		end else if (stop_cnt_r != 2'h3) begin
			stop_cnt_r <= stop_cnt_r + 2'h1;
		end
	end
	// ==========================================
	// Assertions
	chk_setup_ready: assert property (psel && !penable |=> pready)
		else $error("pready missing in access cycle");
	chk_ready_pulse: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	chk_err_access: assert property (pslverr |-> pready && psel && penable)
		else $error("pslverr outside access");
	chk_unmapped_err: assert property (acc && paddr > OFS_PINCFG
		|-> pslverr && (pwrite || prdata == 32'h0))
		else $error("unmapped access not refused");
	chk_mapped_ok: assert property (acc && paddr <= OFS_PINCFG && paddr[1:0] == 2'h0 |-> !pslverr)
		else $error("mapped access refused");
	chk_mask_read: assert property (acc && !pwrite && paddr == OFS_IRQ_MASK
		|-> prdata == {29'h0, mask_r})
		else $error("mask readback wrong");
	chk_masked_quiet: assert property (mask_r == 3'h7 && $past(mask_r) == 3'h7 |-> !irq)
		else $error("irq high while all masked");
	chk_oe_follows: assert property (pin_r == $past(pin_r, 2)
		|-> shared_port_pin_oe == pin_r)
		else $error("pin enable differs from config");
	chk_out_gated: assert property (shared_port_pin_out |-> shared_port_pin_oe)
		else $error("timer output driven while pin is input");
	chk_stop_count: assert property (acc && !pwrite && paddr == OFS_COUNT
		&& opm_r == OPM_STOP && stop_cnt_r[1] |-> prdata == 32'h0)
		else $error("count moved while stopped");
endmodule

bind tcc_top tcc_monitor #(.CNT_W(CNT_W)) u_mon (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .edge_input_first(edge_input_first),
	.shared_port_pin_in(shared_port_pin_in), .shared_port_pin_out(shared_port_pin_out),
	.shared_port_pin_oe(shared_port_pin_oe), .irq(irq));

// [tcc_tb_top.sv]
// Testbench: self-checking regression of the capture/compare timer
`timescale 1ns/1ps
module tcc_tb_top
	import tcc_pkg::*;
;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic edge_input_first = 1'b0;
	logic shared_port_pin_in = 1'b0;
	logic pin_out;
	logic pin_oe;
	logic irq;
	logic [31:0] q;
	logic perr;
	logic [31:0] c0;
	logic [31:0] c1;
	logic [31:0] m0;
	logic [31:0] m1;
	logic [31:0] k0;
	logic [31:0] k1;
	logic [31:0] seed = 32'h000054b8;
	int mismatches = 0;
	int n_checks = 0;
	int sh;
	always #2 pclk = ~pclk;
	tcc_top #(.CNT_W(16)) dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .edge_input_first(edge_input_first),
		.shared_port_pin_in(shared_port_pin_in), .shared_port_pin_out(pin_out),
		.shared_port_pin_oe(pin_oe), .irq(irq));
	// ==========================================
	// Helpers
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			mismatches++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		q = prdata;
		perr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic rc(input string nm, input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(nm, e, q);
	endtask
	task automatic pulse(input bit s);
		int w;
		w = 4 + int'(rnd() & 32'h3);
		if (s) shared_port_pin_in <= 1'b1;
		else edge_input_first <= 1'b1;
		repeat (w) @(posedge pclk);
		if (s) shared_port_pin_in <= 1'b0;
		else edge_input_first <= 1'b0;
		repeat (w) @(posedge pclk);
	endtask
	task automatic cap(input bit s, input logic [7:0] ra);
		apb(1'b0, OFS_COUNT, 32'h0);
		c0 = q;
		pulse(s);
		apb(1'b0, OFS_COUNT, 32'h0);
		c1 = q;
		apb(1'b0, ra, 32'h0);
		chk("capture_range", 32'h1, {31'h0, (q >= c0) && (q <= c1)});
	endtask
	task automatic results();
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	initial begin
		#40000;
		mismatches++;
		results();
	end
	// ==========================================
	// Scenarios
	initial begin
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rc("mode", OFS_MODE, 32'h0);
		rc("ccctrl", OFS_CCCTRL, 32'h0);
		rc("presc", OFS_PRESC, 32'h0);
		rc("mask", OFS_IRQ_MASK, 32'h7);
		rc("hole", 8'h24, 32'h0);
		chk("hole_err", 32'h1, {31'h0, perr});
		edge_input_first <= 1'b1;
		apb(1'b1, OFS_PRESC, 32'h50);
		apb(1'b1, OFS_MODE, 32'h4);
		repeat (8) @(posedge pclk);
		rc("first_en", OFS_IRQ_STAT, 32'h2);
		apb(1'b1, OFS_MODE, 32'h0);
		apb(1'b1, OFS_MODE, 32'h4);
		repeat (8) @(posedge pclk);
		rc("re_en", OFS_IRQ_STAT, 32'h0);
		edge_input_first <= 1'b0;
		for (int m = 1; m < 4; m++) begin
			apb(1'b1, OFS_MODE, 32'(m << 2));
			apb(1'b0, OFS_COUNT, 32'h0);
			c0 = q;
			apb(1'b0, OFS_COUNT, 32'h0);
			chk("count_runs", 32'h1, {31'h0, q > c0});
			apb(1'b1, OFS_MODE, 32'h0);
			rc("count_stop", OFS_COUNT, 32'h0);
		end
		apb(1'b1, OFS_MODE, 32'h4);
		cap(1'b0, OFS_CCSECOND);
		m1 = q;
		rc("stat_second", OFS_IRQ_STAT, 32'h2);
		rc("stat_clear", OFS_IRQ_STAT, 32'h0);
		repeat (3) apb(1'b0, OFS_COUNT, 32'h0);
		rc("no_side", OFS_CCSECOND, m1);
		cap(1'b1, OFS_CCFIRST);
		m0 = q;
		rc("stat_first", OFS_IRQ_STAT, 32'h1);
		apb(1'b1, OFS_IRQ_MASK, 32'h0);
		pulse(1'b0);
		chk("irq_on", 32'h1, {31'h0, irq});
		rc("stat_irq", OFS_IRQ_STAT, 32'h2);
		repeat (2) @(posedge pclk);
		chk("irq_off", 32'h0, {31'h0, irq});
		apb(1'b1, OFS_IRQ_MASK, 32'h2);
		pulse(1'b0);
		chk("irq_masked", 32'h0, {31'h0, irq});
		rc("stat_masked", OFS_IRQ_STAT, 32'h2);
		apb(1'b1, OFS_PINCFG, 32'h1);
		repeat (2) @(posedge pclk);
		chk("oe_on", 32'h1, {31'h0, pin_oe});
		pulse(1'b1);
		rc("pin_ignored", OFS_IRQ_STAT, 32'h0);
		apb(1'b1, OFS_PINCFG, 32'h0);
		repeat (2) @(posedge pclk);
		chk("oe_off", 32'h0, {31'h0, pin_oe});
		apb(1'b1, OFS_MODE, 32'h0);
		apb(1'b1, OFS_CCCTRL, 32'h5);
		rc("kept", OFS_CCFIRST, m0);
		k0 = rnd() & 32'hffff;
		k1 = rnd() & 32'hffff;
		apb(1'b1, OFS_CCFIRST, k0);
		apb(1'b1, OFS_CCSECOND, k1);
		apb(1'b1, OFS_MODE, 32'h4);
		pulse(1'b0);
		pulse(1'b1);
		rc("cmp_first", OFS_CCFIRST, k0);
		rc("cmp_second", OFS_CCSECOND, k1);
		// ==========================================
		// Compare matches set both interrupts; the second-register match toggles the timer output
		apb(1'b1, OFS_MODE, 32'h0);
		apb(1'b1, OFS_PINCFG, 32'h1);
		apb(1'b1, OFS_CCFIRST, 32'h10);
		apb(1'b1, OFS_CCSECOND, 32'h20);
		apb(1'b0, OFS_IRQ_STAT, 32'h0);
		apb(1'b1, OFS_MODE, 32'h4);
		repeat (64) @(posedge pclk);
		chk("toggle", 32'h1, {31'h0, pin_out});
		rc("cmp_stat", OFS_IRQ_STAT, 32'h3);
		apb(1'b1, OFS_PINCFG, 32'h0);
		apb(1'b1, OFS_MODE, 32'h0);
		apb(1'b1, OFS_CCCTRL, 32'h2);
		apb(1'b1, OFS_MODE, 32'h4);
		apb(1'b0, OFS_IRQ_STAT, 32'h0);
		cap(1'b0, OFS_CCFIRST);
		m0 = q;
		rc("rev_stat", OFS_IRQ_STAT, 32'h2);
		pulse(1'b1);
		chk("ext_irq", 32'h1, {31'h0, irq});
		rc("ext_stat", OFS_IRQ_STAT, 32'h1);
		rc("ext_nocap", OFS_CCFIRST, m0);
		apb(1'b1, OFS_IRQ_MASK, 32'h3);
		pulse(1'b1);
		chk("ext_masked", 32'h0, {31'h0, irq});
		rc("ext_stat2", OFS_IRQ_STAT, 32'h1);
		// ==========================================
		// Divided count clocks
		for (int s = 1; s < 3; s++) begin
			apb(1'b1, OFS_MODE, 32'h0);
			apb(1'b1, OFS_PRESC, 32'h50 | s);
			apb(1'b1, OFS_MODE, 32'h4);
			apb(1'b0, OFS_COUNT, 32'h0);
			c0 = q;
			repeat (1024) @(posedge pclk);
			apb(1'b0, OFS_COUNT, 32'h0);
			sh = (s == 1) ? int'(DIV_EXP1) : int'(DIV_EXP2);
			k0 = q - c0;
			chk("div_rate", 32'h1, {31'h0, k0 >= (1027 >> sh) && k0 <= (1027 >> sh) + 1});
		end
		// ==========================================
		// Edge-clocked counting, both registers in compare mode
		apb(1'b1, OFS_MODE, 32'h0);
		apb(1'b1, OFS_CCCTRL, 32'h5);
		apb(1'b1, OFS_PRESC, 32'h53);
		apb(1'b1, OFS_MODE, 32'h4);
		repeat (3) pulse(1'b0);
		rc("edge_count", OFS_COUNT, 32'h3);
		apb(1'b1, OFS_MODE, 32'h0);
		results();
	end
endmodule
